// ===== sswoc_cfg.svh
// Constants of the synchronous SRAM write and output control block
`ifndef SSWOC_CFG_SVH
`define SSWOC_CFG_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define SSWOC_LANES_DEF    4            // Default number of byte lanes
`define SSWOC_BURST_W      2            // Width of the burst counter

// ****************************************************************
// Reset values and counter step
// ****************************************************************
`define SSWOC_RST_ADDR     2'h0         // Burst address after reset
`define SSWOC_RST_OFS      2'h0         // Burst offset after reset
`define SSWOC_RST_ACTIVE   1'b0         // No burst open after reset
`define SSWOC_BURST_STEP   2'h1         // Counter step per advance

`endif

// ===== sswoc_pkg.sv
// Types shared by the synchronous SRAM write and output control block
package sswoc_pkg;

    // Operation registered for the current cycle
    typedef enum logic [1:0] {
        SSWOC_IDLE,
        SSWOC_READ,
        SSWOC_WRITE
    } sswoc_cyc_e;

    // Burst counter value
    typedef logic [1:0] sswoc_burst_t;

endpackage

// ===== sswoc_lane.sv
// One byte lane write strobe decoder, covering data byte and parity bit
`timescale 1ns/1ps

module sswoc_lane (
    input  wire logic global_write_n,
    input  wire logic byte_write_enable_n,
    input  wire logic lane_write_n,
    input  wire logic write_allowed,
    output logic      lane_write
);

    // ****************************************************************
    // Lane decode
    // ****************************************************************
    // Global write takes every lane, otherwise the lane's own input
    always_comb begin
        lane_write = write_allowed &
                     (~global_write_n |
                      (~byte_write_enable_n & ~lane_write_n));
    end

endmodule

// ===== sswoc_ctrl.sv
// Write decode, lane strobes, burst counter and data pin enable control
//
// Behaviour
// - Write when global, or enable with lane
// - Read when all write inputs are high
// - Pin drive follows cycle and unregistered enable
// - Processor strobe forces read, ignores write inputs
// - Write only after processor strobe or controller strobe
// - Output enable masked during write cycles
// - Read: float if enable high, else drive
// - Lane low writes its byte and parity
// - Any combination of lanes written together
// - Lanes indexed zero upward, two four eight
// - Advance low steps two-bit burst counter
`timescale 1ns/1ps
`include "sswoc_cfg.svh"

module sswoc_ctrl #(
    parameter int LANES = `SSWOC_LANES_DEF   // 2, 4 or 8 byte lanes
) (
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    input  wire logic                    clk_en,
    input  wire logic                    chip_sel,
    input  wire logic                    cpu_addr_strobe_n,
    input  wire logic                    ctrl_addr_strobe_n,
    input  wire logic                    burst_advance_n,
    input  wire logic                    global_write_n,
    input  wire logic                    byte_write_enable_n,
    input  wire logic [LANES-1:0]        lane_write_n,
    input  wire logic                    oe_n,
    input  wire logic                    burst_linear,
    input  wire sswoc_pkg::sswoc_burst_t addr_lsb,
    output sswoc_pkg::sswoc_cyc_e        cycle_ff,
    output logic                         write_ff,
    output logic [LANES-1:0]             lane_we_ff,
    output sswoc_pkg::sswoc_burst_t      burst_addr_ff,
    output logic                         dq_oe_n
);
    import sswoc_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic                  write_req;      // Write inputs ask for a write
    logic                  cpu_start;      // Processor strobe, selected
    logic                  ctrl_start;     // Controller strobe, selected
    logic                  cont_cycle;     // Neither strobe, burst open
    logic                  write_allowed;  // Write may be taken now
    logic [LANES-1:0]      lane_write;     // Decoded lane strobes
    logic                  active_ff;      // A burst is open
    sswoc_burst_t          start_ff;       // First address of the burst
    sswoc_burst_t          ofs_ff;         // Offset into the burst
    sswoc_burst_t          nxt_ofs;        // Offset after this cycle
    sswoc_burst_t          nxt_addr;       // Address after this cycle
    sswoc_cyc_e            nxt_cycle;      // Operation of next cycle

    // ****************************************************************
    // Cycle decode
    // ****************************************************************
    // Global write low, or byte enable low with any lane low
    always_comb begin
        write_req = ~global_write_n |
                    (~byte_write_enable_n & ~(&lane_write_n));
    end

    // Strobe classification; processor strobe has priority
    always_comb begin
        cpu_start  = ~cpu_addr_strobe_n & chip_sel;
        ctrl_start = cpu_addr_strobe_n & ~ctrl_addr_strobe_n & chip_sel;
        cont_cycle = cpu_addr_strobe_n & ctrl_addr_strobe_n & active_ff;
        // Never on the processor strobe cycle itself
        write_allowed = ctrl_start | cont_cycle;
    end

    // Next operation
    always_comb begin
        if (cpu_start) begin
            // Write inputs are ignored here
            nxt_cycle = SSWOC_READ;
        end else if (ctrl_start || cont_cycle) begin
            // All write inputs high gives a read
            nxt_cycle = write_req ? SSWOC_WRITE : SSWOC_READ;
        end else begin
            // Deselect, or no burst open
            nxt_cycle = SSWOC_IDLE;
        end
    end

    // ****************************************************************
    // Lane strobes
    // ****************************************************************
    // One decoder per lane, any set of lanes at once
    genvar gi;
    generate
        for (gi = 0; gi < LANES; gi++) begin : g_lane
            sswoc_lane u_lane (
                .global_write_n      (global_write_n),
                .byte_write_enable_n (byte_write_enable_n),
                .lane_write_n        (lane_write_n[gi]),
                .write_allowed       (write_allowed & write_req),
                .lane_write          (lane_write[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Burst counter
    // ****************************************************************
    // Offset loads on a strobe and steps on advance
    always_comb begin
        if (cpu_start || ctrl_start) begin
            nxt_ofs = `SSWOC_RST_OFS;
        end else if (cont_cycle && !burst_advance_n) begin
            nxt_ofs = sswoc_burst_t'(ofs_ff + `SSWOC_BURST_STEP);
        end else begin
            nxt_ofs = ofs_ff;
        end
        // Linear adds the offset, interleaved mixes it in
        if (cpu_start || ctrl_start) begin
            nxt_addr = addr_lsb;
        end else if (burst_linear) begin
            nxt_addr = sswoc_burst_t'(start_ff + nxt_ofs);
        end else begin
            nxt_addr = start_ff ^ nxt_ofs;
        end
    end

    // Burst start address and offset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            start_ff <= `SSWOC_RST_ADDR;
            ofs_ff   <= `SSWOC_RST_OFS;
        end else if (clk_en) begin
            if (cpu_start || ctrl_start) begin
                start_ff <= addr_lsb;
            end
            ofs_ff <= nxt_ofs;
        end
    end

    // Registered burst address
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            burst_addr_ff <= `SSWOC_RST_ADDR;
        end else if (clk_en) begin
            burst_addr_ff <= nxt_addr;
        end
    end

    // ****************************************************************
    // Cycle state
    // ****************************************************************
    // Burst opens on a selected strobe, closes on a strobe while deselected
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            active_ff <= `SSWOC_RST_ACTIVE;
        end else if (clk_en) begin
            if (!cpu_addr_strobe_n || !ctrl_addr_strobe_n) begin
                active_ff <= chip_sel;
            end
        end
    end

    // Operation, write flag and lane strobes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cycle_ff   <= SSWOC_IDLE;
            write_ff   <= 1'b0;
            lane_we_ff <= '0;
        end else if (clk_en) begin
            cycle_ff   <= nxt_cycle;
            write_ff   <= (nxt_cycle == SSWOC_WRITE);
            lane_we_ff <= lane_write;
        end
    end

    // ****************************************************************
    // Data pin enable
    // ****************************************************************
    // Enable is not registered; masked outside reads
    always_comb begin
        case (cycle_ff)
            SSWOC_READ:  dq_oe_n = oe_n;
            SSWOC_WRITE: dq_oe_n = 1'b1;
            SSWOC_IDLE:  dq_oe_n = 1'b1;
            default:     dq_oe_n = 1'b1;
        endcase
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_write_take;
        clk_en && write_req && (ctrl_start || cont_cycle);
    endsequence

    sequence s_step;
        clk_en && cont_cycle && !burst_advance_n && burst_linear;
    endsequence

    property p_write_dec;
        s_write_take |=> cycle_ff == SSWOC_WRITE && write_ff;
    endproperty
    a_write_dec: assert property (p_write_dec)
        else $error("write not taken");

    property p_read_dec;
        clk_en && global_write_n && byte_write_enable_n &&
            (ctrl_start || cont_cycle) |=> cycle_ff == SSWOC_READ;
    endproperty
    a_read_dec: assert property (p_read_dec)
        else $error("read not taken");

    property p_oe_comb;
        cycle_ff == SSWOC_READ |-> dq_oe_n == oe_n;
    endproperty
    a_oe_comb: assert property (p_oe_comb)
        else $error("pin enable not following output enable in read");

    property p_cpu_read;
        clk_en && cpu_start |=> cycle_ff == SSWOC_READ && lane_we_ff == '0;
    endproperty
    a_cpu_read: assert property (p_cpu_read)
        else $error("processor strobe did not give a read");

    property p_no_write_idle;
        clk_en && !write_allowed |=> !write_ff && lane_we_ff == '0;
    endproperty
    a_no_write_idle: assert property (p_no_write_idle)
        else $error("write outside an allowed cycle");

    property p_write_float;
        write_ff |-> dq_oe_n;
    endproperty
    a_write_float: assert property (p_write_float)
        else $error("pins driven during write");

    property p_lanes;
        s_write_take and global_write_n
            |=> lane_we_ff == ~$past(lane_write_n);
    endproperty
    a_lanes: assert property (p_lanes)
        else $error("lane strobes differ from lane inputs");

    property p_step;
        s_step |=> burst_addr_ff ==
            sswoc_burst_t'($past(burst_addr_ff) + `SSWOC_BURST_STEP);
    endproperty
    a_step: assert property (p_step)
        else $error("burst counter did not step");

    property p_hold;
        clk_en && cont_cycle && burst_advance_n
            |=> $stable(burst_addr_ff);
    endproperty
    a_hold: assert property (p_hold)
        else $error("burst address moved without advance");

endmodule

// ===== sswoc_host_model.sv
// Bus master model driving the synchronous SRAM control pins
`timescale 1ns/1ps

module sswoc_host_model (
    input  wire logic [13:0]     cmd,
    output logic                 chip_sel,
    output logic                 cpu_addr_strobe_n,
    output logic                 ctrl_addr_strobe_n,
    output logic                 burst_advance_n,
    output logic                 global_write_n,
    output logic                 byte_write_enable_n,
    output logic [3:0]           lane_write_n,
    output sswoc_pkg::sswoc_burst_t addr_lsb,
    output logic                 burst_linear,
    output logic                 oe_n
);
    import sswoc_pkg::*;

    // ****************************************************************
    // Bus drive
    // ****************************************************************
    logic oe_req_n;   // Output enable asked for by the bench
    logic wr_begin;   // Write controls presented without a processor strobe

    // Unpack the command; the bench changes it after the falling edge
    assign {chip_sel, cpu_addr_strobe_n, ctrl_addr_strobe_n,
            burst_advance_n, global_write_n, byte_write_enable_n,
            lane_write_n, addr_lsb,
            burst_linear, oe_req_n} = cmd;

    // Write controls presented on a controller strobe or a continue cycle
    assign wr_begin = cpu_addr_strobe_n
                      & (~global_write_n
                         | (~byte_write_enable_n & ~&lane_write_n));

    // Outputs made to float before a write opens, free afterwards
    assign oe_n = oe_req_n | wr_begin;
endmodule

// ===== testbench.sv
// Table driven testbench of the SRAM write and output control block
`timescale 1ns/1ps

module testbench;
    import sswoc_pkg::*;

    // ****************************************************************
    // Signals
    // ****************************************************************
    typedef struct packed {
        logic [5:0]   bus;   // Select, strobes, advance, write inputs
        logic [3:0]   ln;    // Lane write inputs, low active
        logic [1:0]   a;     // Start address
        logic [1:0]   lo;    // Linear order and output enable
        sswoc_cyc_e   cyc;   // Expected cycle
        logic         wr;    // Expected write flag
        logic [3:0]   we;    // Expected lane strobes
        sswoc_burst_t ba;    // Expected burst address
    } sswoc_row_s;
    localparam logic [13:0] idle_cmd = 14'h3FF3;
    localparam logic [8:0]  rst_val  = {SSWOC_IDLE, 1'h0, 4'h0, 2'h0};
    logic sys_clk = 1'h0;
    logic rst     = 1'h1;
    logic clk_en  = 1'h1;
    logic [13:0] cmd = idle_cmd;
    logic chip_sel, cpu_addr_strobe_n, ctrl_addr_strobe_n;
    logic burst_advance_n, global_write_n, byte_write_enable_n;
    logic [3:0] lane_write_n;
    logic [3:0] lane_we_ff;
    sswoc_burst_t addr_lsb;
    sswoc_burst_t burst_addr_ff;
    logic burst_linear, oe_n, write_ff, dq_oe_n;
    sswoc_cyc_e cycle_ff;
    logic [8:0] got_st;   // Registered state as one word
    logic [8:0] exp_st;   // Expected state of the current check
    int fail_count = 0;
    int check_count = 0;
    sswoc_row_s rows [9] = '{
        '{6'h36, 4'h5, 2'h2, 2'h2, SSWOC_WRITE, 1'h1, 4'hA, 2'h2},
        '{6'h39, 4'hF, 2'h0, 2'h2, SSWOC_WRITE, 1'h1, 4'hF, 2'h3},
        '{6'h3B, 4'hF, 2'h0, 2'h2, SSWOC_READ,  1'h0, 4'h0, 2'h0},
        '{6'h2D, 4'hF, 2'h1, 2'h2, SSWOC_READ,  1'h0, 4'h0, 2'h1},
        '{6'h3E, 4'h0, 2'h0, 2'h2, SSWOC_WRITE, 1'h1, 4'hF, 2'h1},
        '{6'h37, 4'h0, 2'h3, 2'h2, SSWOC_READ,  1'h0, 4'h0, 2'h3},
        '{6'h36, 4'hF, 2'h0, 2'h2, SSWOC_READ,  1'h0, 4'h0, 2'h0},
        '{6'h36, 4'h7, 2'h1, 2'h0, SSWOC_WRITE, 1'h1, 4'h8, 2'h1},
        '{6'h3A, 4'hE, 2'h0, 2'h0, SSWOC_WRITE, 1'h1, 4'h1, 2'h0}};

    // Clock of 50 ns period
    always #25 sys_clk = ~sys_clk;

    // Cycle, write flag, lane strobes and burst address together
    assign got_st = {cycle_ff, write_ff, lane_we_ff, burst_addr_ff};

    // ****************************************************************
    // Instances
    // ****************************************************************
    sswoc_host_model i_host (.cmd(cmd), .chip_sel(chip_sel),
        .cpu_addr_strobe_n(cpu_addr_strobe_n),
        .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
        .burst_advance_n(burst_advance_n), .global_write_n(global_write_n),
        .byte_write_enable_n(byte_write_enable_n),
        .lane_write_n(lane_write_n), .addr_lsb(addr_lsb),
        .burst_linear(burst_linear), .oe_n(oe_n));
    sswoc_ctrl #(.LANES(4)) i_dut (.sys_clk(sys_clk), .rst(rst),
        .clk_en(clk_en), .chip_sel(chip_sel),
        .cpu_addr_strobe_n(cpu_addr_strobe_n),
        .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
        .burst_advance_n(burst_advance_n), .global_write_n(global_write_n),
        .byte_write_enable_n(byte_write_enable_n),
        .lane_write_n(lane_write_n), .oe_n(oe_n),
        .burst_linear(burst_linear), .addr_lsb(addr_lsb),
        .cycle_ff(cycle_ff), .write_ff(write_ff), .lane_we_ff(lane_we_ff),
        .burst_addr_ff(burst_addr_ff), .dq_oe_n(dq_oe_n));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // Compare registered state: cycle, write, lanes, burst address
    task automatic chk_reg(input logic [8:0] got, input logic [8:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %0t state got %h exp %h", $time, got, exp);
        end
    endtask

    // Compare the data pin enable
    task automatic chk_pin(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %0t pin got %h exp %h", $time, got, exp);
        end
    endtask

    // Present a command after the falling edge, settle past the rise
    task automatic step(input logic [13:0] c);
        @(negedge sys_clk) cmd = c;
        @(posedge sys_clk) #10;
    endtask

    // Pulse output enable low mid-cycle, check the pins against exp_low, then check them high
    task automatic oe_probe(input logic exp_low);
        cmd[0] = 1'h0;
        #5 chk_pin(dq_oe_n, exp_low);
        cmd[0] = 1'h1;
        #5 chk_pin(dq_oe_n, 1'h1);
    endtask

    // Print counts and verdict, then stop
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        repeat (3) @(posedge sys_clk);
        #10 chk_reg({cycle_ff, write_ff, lane_we_ff, burst_addr_ff}, rst_val);
        chk_pin(dq_oe_n, 1'h1);
        @(negedge sys_clk) rst = 1'h0;
        // Table rows, one operation per cycle
        foreach (rows[i]) begin
            step({rows[i].bus, rows[i].ln, rows[i].a, rows[i].lo});
            exp_st = {rows[i].cyc, rows[i].wr, rows[i].we, rows[i].ba};
            chk_reg(got_st, exp_st);
            oe_probe(rows[i].cyc != SSWOC_READ);
        end
        // Frozen clock enable ignores a processor strobe
        @(negedge sys_clk) clk_en = 1'h0;
        step({6'h2D, 4'hF, 2'h1, 2'h2});
        chk_reg({cycle_ff, write_ff, lane_we_ff, burst_addr_ff},
                {SSWOC_WRITE, 1'h1, 4'h1, 2'h0});
        @(negedge sys_clk) clk_en = 1'h1;
        // Deselect, then a continue write that must be refused
        step({6'h15, 4'h0, 2'h1, 2'h2});
        chk_reg({cycle_ff, write_ff, lane_we_ff, 2'h0}, rst_val);
        oe_probe(1'h1);
        step({6'h39, 4'h0, 2'h0, 2'h2});
        chk_reg({cycle_ff, write_ff, lane_we_ff, 2'h0}, rst_val);
        // Reset in mid-run while a write is presented
        @(negedge sys_clk) rst = 1'h1;
        step({6'h36, 4'h0, 2'h2, 2'h2});
        chk_reg({cycle_ff, write_ff, lane_we_ff, burst_addr_ff}, rst_val);
        chk_pin(dq_oe_n, 1'h1);
        @(negedge sys_clk) rst = 1'h0;
        // First request on the first edge after release is taken
        cmd = {rows[0].bus, rows[0].ln, rows[0].a, rows[0].lo};
        @(posedge sys_clk) #10;
        exp_st = {rows[0].cyc, rows[0].wr, rows[0].we, rows[0].ba};
        chk_reg(got_st, exp_st);
        cmd = idle_cmd;
        give_verdict();
    end
endmodule
